//--- dtx_defs.vh
// shared constants for the dual-rail transmit line driver
`ifndef DTX_DEFS_VH
`define DTX_DEFS_VH
`define DTX_CLK_PERIOD_NS 10
`define DTX_NUM_CH 12
`define DTX_SYNC_RST 2'h0
`define DTX_HALF_BIT_CYCLES 4
`define DTX_TX_ON_RST 1'h1
`endif

//--- dtx_framer.sv
// framer model: bit clock and line-coded dual-rail symbols
`timescale 1ns/1ps
module dtx_framer(input wire [1:0] sym_i, output reg bclk_o = 0, output reg pos_o = 0,
	output reg neg_o = 0);
	always #62.5 bclk_o = ~bclk_o;
	// rails move at the falling edge, far from the capture edge
	always @(negedge bclk_o) begin
		pos_o <= sym_i[0];
		neg_o <= sym_i[1] & ~sym_i[0];
	end
endmodule

//--- dtx_line_driver.v
// dual-rail transmit line driver: rail sampling, bipolar pulse shaping, tri-state control
`timescale 1ns/1ps
`include "dtx_defs.vh"
module dtx_line_driver #(
	parameter NUM_CH = `DTX_NUM_CH
) (
	input wire sys_clk_i,
	input wire rstn_i,
	input wire [NUM_CH-1:0] transmit_bit_clock_i,
	input wire [NUM_CH-1:0] pos_rail_in_i,
	input wire [NUM_CH-1:0] neg_rail_in_i,
	input wire [NUM_CH-1:0] dual_rail_mode_i,
	input wire transmitter_on_i,
	input wire [NUM_CH-1:0] chan_tx_on_i,
	output wire [NUM_CH-1:0] line_out_positive_o,
	output wire [NUM_CH-1:0] line_out_positive_oe_n_o,
	output wire [NUM_CH-1:0] line_out_negative_o,
	output wire [NUM_CH-1:0] line_out_negative_oe_n_o
);

////////////////////////////////////////////////////////////////////////////////
// global pin synchroniser
// the pin idles high, so reset loads the powered-on level
reg [1:0] on_sync_reg;
wire [1:0] on_sync_next;
wire pin_on;

assign on_sync_next = {on_sync_reg[0], transmitter_on_i};
assign pin_on = on_sync_reg[1];

always @(posedge sys_clk_i or negedge rstn_i) begin
	if (!rstn_i) begin
		on_sync_reg <= {`DTX_TX_ON_RST, `DTX_TX_ON_RST};
	end else begin
		on_sync_reg <= on_sync_next;
	end
end

////////////////////////////////////////////////////////////////////////////////
// per channel datapath
genvar ch;
generate
	for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_ch
		reg [1:0] clk_sync_reg;
		reg clk_prev_reg;
		reg [1:0] pos_sync_reg;
		reg [1:0] neg_sync_reg;
		reg [1:0] mode_sync_reg;
		reg [1:0] en_sync_reg;
		reg pos_bit_reg;
		reg neg_bit_reg;
		reg tip_reg;
		reg ring_reg;
		reg oe_n_reg;

		wire [1:0] clk_sync_next;
		wire [1:0] pos_sync_next;
		wire [1:0] neg_sync_next;
		wire [1:0] mode_sync_next;
		wire [1:0] en_sync_next;

		reg pos_bit_next;
		reg neg_bit_next;
		reg tip_next;
		reg ring_next;
		reg oe_n_next;

		wire clk_rise;
		wire neg_eff;
		wire chan_on;

		// rails arrive with the link clock, so all pass the same two-stage delay
		assign clk_sync_next = {clk_sync_reg[0], transmit_bit_clock_i[ch]};
		assign pos_sync_next = {pos_sync_reg[0], pos_rail_in_i[ch]};
		assign neg_sync_next = {neg_sync_reg[0], neg_rail_in_i[ch]};
		assign mode_sync_next = {mode_sync_reg[0], dual_rail_mode_i[ch]};
		assign en_sync_next = {en_sync_reg[0], chan_tx_on_i[ch]};

		// rise is seen in the cycle the synced clock first reads high, so rails have long settled by capture
		assign clk_rise = clk_sync_reg[1] & ~clk_prev_reg;
		// single-rail data is not encoded here, so negative rail is simply masked
		assign neg_eff = neg_sync_reg[1] & mode_sync_reg[1];
		assign chan_on = pin_on & en_sync_reg[1];

		// every pin input passes two flops before any logic reads it
		always @(posedge sys_clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				clk_sync_reg <= `DTX_SYNC_RST;
			end else begin
				clk_sync_reg <= clk_sync_next;
			end
		end

		always @(posedge sys_clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				clk_prev_reg <= 1'h0;
			end else begin
				clk_prev_reg <= clk_sync_reg[1];
			end
		end

		always @(posedge sys_clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				pos_sync_reg <= `DTX_SYNC_RST;
			end else begin
				pos_sync_reg <= pos_sync_next;
			end
		end

		always @(posedge sys_clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				neg_sync_reg <= `DTX_SYNC_RST;
			end else begin
				neg_sync_reg <= neg_sync_next;
			end
		end

		always @(posedge sys_clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				mode_sync_reg <= `DTX_SYNC_RST;
			end else begin
				mode_sync_reg <= mode_sync_next;
			end
		end

		always @(posedge sys_clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				en_sync_reg <= {`DTX_TX_ON_RST, `DTX_TX_ON_RST};
			end else begin
				en_sync_reg <= en_sync_next;
			end
		end

		// captured rails hold until the next bit clock rise
		always @* begin
			pos_bit_next = pos_bit_reg;
			if (clk_rise) begin
				pos_bit_next = pos_sync_reg[1];
			end
		end

		always @* begin
			neg_bit_next = neg_bit_reg;
			if (clk_rise) begin
				neg_bit_next = neg_eff;
			end
		end

		always @(posedge sys_clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				pos_bit_reg <= 1'h0;
			end else begin
				pos_bit_reg <= pos_bit_next;
			end
		end

		always @(posedge sys_clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				neg_bit_reg <= 1'h0;
			end else begin
				neg_bit_reg <= neg_bit_next;
			end
		end

		// both rails high: no pulse rather than a shorted driver
		always @* begin
			tip_next = pos_bit_reg & ~neg_bit_reg;
		end

		always @* begin
			ring_next = neg_bit_reg & ~pos_bit_reg;
		end

		// a dropped enable floats the pair within three edges
		always @* begin
			oe_n_next = ~chan_on;
		end

		// line levels and enable leave from flops, never from gates
		always @(posedge sys_clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				tip_reg <= 1'h0;
			end else begin
				tip_reg <= tip_next;
			end
		end

		always @(posedge sys_clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				ring_reg <= 1'h0;
			end else begin
				ring_reg <= ring_next;
			end
		end

		always @(posedge sys_clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				oe_n_reg <= 1'h1;
			end else begin
				oe_n_reg <= oe_n_next;
			end
		end

		// both halves of the pair share one enable, so they float together
		assign line_out_positive_o[ch] = tip_reg;
		assign line_out_negative_o[ch] = ring_reg;
		assign line_out_positive_oe_n_o[ch] = oe_n_reg;
		assign line_out_negative_oe_n_o[ch] = oe_n_reg;
	end
endgenerate

endmodule

//--- dtx_line_driver_chk.sv
// line driver port assertions
`timescale 1ns/1ps
module dtx_line_driver_chk #(parameter NUM_CH = 12) (input wire sys_clk_i, rstn_i,
	input wire transmitter_on_i,
	input wire [NUM_CH-1:0] transmit_bit_clock_i, pos_rail_in_i, neg_rail_in_i, dual_rail_mode_i,
	input wire [NUM_CH-1:0] chan_tx_on_i, line_out_positive_o, line_out_negative_o,
	input wire [NUM_CH-1:0] line_out_positive_oe_n_o, line_out_negative_oe_n_o);
	wire tp = line_out_positive_o[0], rg = line_out_negative_o[0], bc = transmit_bit_clock_i[0];
	wire pe = line_out_positive_oe_n_o[0], ne = line_out_negative_oe_n_o[0];
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	a_cap_edge: assert property ($changed(tp) |-> $past(bc, 3)) else $error("no edge");
	a_pos_pulse: assert property ($rose(tp) |-> $past(pos_rail_in_i[0], 4)) else $error("tip");
	a_neg_pulse: assert property ($rose(rg) |-> $past(neg_rail_in_i[0], 4)) else $error("ring");
	a_single_ign: assert property ($rose(rg) |-> $past(dual_rail_mode_i[0], 4)) else $error("mode");
	a_pin_off: assert property ((!transmitter_on_i) [*5] |-> pe && ne) else $error("pin off");
	a_chan_off: assert property ((!chan_tx_on_i[0]) [*5] |-> pe && ne) else $error("chan off");
	a_on_drive: assert property ((transmitter_on_i && chan_tx_on_i[0]) [*5] |-> !pe && !ne) else $error("on");
	cover property ($rose(tp));
	cover property ($rose(rg));
	cover property ($rose(pe));
endmodule
bind dtx_line_driver dtx_line_driver_chk #(.NUM_CH(NUM_CH)) u_chk (.sys_clk_i(sys_clk_i),
	.rstn_i(rstn_i), .transmitter_on_i(transmitter_on_i),
	.transmit_bit_clock_i(transmit_bit_clock_i), .pos_rail_in_i(pos_rail_in_i),
	.neg_rail_in_i(neg_rail_in_i), .dual_rail_mode_i(dual_rail_mode_i),
	.chan_tx_on_i(chan_tx_on_i), .line_out_positive_o(line_out_positive_o),
	.line_out_negative_o(line_out_negative_o),
	.line_out_positive_oe_n_o(line_out_positive_oe_n_o),
	.line_out_negative_oe_n_o(line_out_negative_oe_n_o));

//--- dtx_line_driver_test.sv
// bench: framer drives rails, scoreboard checks line outputs
`timescale 1ns/1ps
module dtx_line_driver_test;
	reg sys_clk_i = 0, rstn_i = 0, transmitter_on_i = 1;
	reg [11:0] dual_rail_mode_i = 12'h000, chan_tx_on_i = 12'hFFF, m;
	reg [31:0] r;
	reg [47:0] e, s, q[$];
	integer errors = 0, cmp_count = 0, i;
	wire bclk, pos, neg;
	wire [11:0] transmit_bit_clock_i = {12{bclk}}, pos_rail_in_i = {12{pos}}, neg_rail_in_i = {12{neg}};
	wire [11:0] line_out_positive_o, line_out_positive_oe_n_o;
	wire [11:0] line_out_negative_o, line_out_negative_oe_n_o;
	dtx_framer frm (.sym_i(r[1:0]), .bclk_o(bclk), .pos_o(pos), .neg_o(neg));
	dtx_line_driver dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
		.transmit_bit_clock_i(transmit_bit_clock_i), .pos_rail_in_i(pos_rail_in_i),
		.neg_rail_in_i(neg_rail_in_i), .dual_rail_mode_i(dual_rail_mode_i),
		.transmitter_on_i(transmitter_on_i), .chan_tx_on_i(chan_tx_on_i),
		.line_out_positive_o(line_out_positive_o),
		.line_out_positive_oe_n_o(line_out_positive_oe_n_o),
		.line_out_negative_o(line_out_negative_o),
		.line_out_negative_oe_n_o(line_out_negative_oe_n_o));
	always #5 sys_clk_i = ~sys_clk_i;
	task chk(input [47:0] seen, input [47:0] exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp) errors = errors + 1;
		if (seen !== exp) $display("Error %0t seen %h exp %h", $time, seen, exp);
	endtask
	task final_report;
		$display("compares %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// masked lines are floating, so their level is not judged
	// looked at on a falling edge, well after the capture edge has settled them
	always @(posedge bclk) begin
		repeat (5) @(negedge sys_clk_i);
		if (q.size() > 0) begin
			e = q.pop_front();
			s = {line_out_positive_o & ~e[11:0], line_out_negative_o & ~e[11:0],
				line_out_positive_oe_n_o, line_out_negative_oe_n_o};
			chk(s, e);
		end
	end
	initial begin
		r = $urandom(3);
		repeat (5) @(posedge sys_clk_i);
		rstn_i <= 1;
		for (i = 0; i < 80; i = i + 1) begin
			@(posedge bclk);
			@(posedge sys_clk_i);
			r <= $urandom;
			@(negedge bclk);
			@(posedge sys_clk_i);
			m = (i < 40 || r[26]) ? r[25:14] : 12'h000;
			dual_rail_mode_i <= r[13:2];
			chan_tx_on_i <= r[25:14];
			transmitter_on_i <= i < 40 || r[26];
			q.push_back({{12{r[0]}} & m, {12{r[1] & ~r[0]}} & r[13:2] & m, ~m, ~m});
			if (i % 40 == 39) $display("test %0d done", i / 40);
		end
		repeat (30) @(posedge sys_clk_i);
		final_report;
	end
	initial begin
		repeat (3000) @(posedge sys_clk_i);
		errors = errors + 1;
		final_report;
	end
endmodule
